// [common/dpbf_params.svh]
`ifndef DPBF_PARAMS_SVH
`define DPBF_PARAMS_SVH

// Memory geometry of each direction
`define DPBF_DEPTH        11'h400
`define DPBF_PTR_W        11
`define DPBF_ADDR_W       10
`define DPBF_DATA_W       36
`define DPBF_OFS_W        10

// Preset almost-flag offsets chosen by the offset selects
`define DPBF_PRESET_64    10'h040
`define DPBF_PRESET_16    10'h010
`define DPBF_PRESET_8     10'h008
`define DPBF_OFS_RESET    10'h008

// Write-clock edges after reset release before input-ready and mode capture
`define DPBF_READY_EDGES  2'h2

// Register byte offsets
`define DPBF_REG_CTRL     8'h00
`define DPBF_REG_STATUS   8'h04
`define DPBF_REG_LEVEL1   8'h08
`define DPBF_REG_LEVEL2   8'h0C
`define DPBF_REG_OFS1     8'h10
`define DPBF_REG_OFS2     8'h14

// Control register: bit 0 gates port A transfers, bit 1 gates port B
`define DPBF_CTRL_RESET   2'h3
`define DPBF_CTRL_A_BIT   0
`define DPBF_CTRL_B_BIT   1

`endif

// [common/dpbf_pkg.sv]
package dpbf_pkg;

   // Parallel offset loading sequence
   typedef enum logic [2:0] {
      DPBF_PR_OFF = 3'b000,
      DPBF_PR_Y1  = 3'b001,
      DPBF_PR_X1  = 3'b010,
      DPBF_PR_Y2  = 3'b011,
      DPBF_PR_X2  = 3'b100
   } dpbf_prog_t;

   // One direction of the pair
   typedef struct packed {
      logic [10:0] wptr;
      logic [10:0] rptr;
      logic [10:0] wg_s1;
      logic [10:0] wg_s2;
      logic [10:0] rg_s1;
      logic [10:0] rg_s2;
      logic        ir;
      logic        orf;
      logic        ae_n;
      logic        af_n;
      logic        fall_through_mode;
      logic        mail_n;
      logic [1:0]  wcnt;
      logic [35:0] dout;
      logic [35:0] mail;
      logic [9:0]  xoff;
      logic [9:0]  yoff;
   } dpbf_fifo_t;

   typedef struct packed {
      dpbf_fifo_t [1:0] fifo;
      dpbf_prog_t       prog;
      logic             a_clk_prev;
      logic             b_clk_prev;
      logic [1:0]       mres_prev;
      logic [1:0]       ctrl;
      logic [31:0]      prdata;
      logic             slverr;
      logic [35:0]      a_dout;
      logic [35:0]      b_dout;
   } dpbf_state_t;

endpackage

// [design/dpbf_sync.sv]
// Two-stage synchroniser for pins arriving from outside the clk_sys domain
module dpbf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dpbf_sync_t;

   dpbf_sync_t st_q;
   dpbf_sync_t st_d;

   // First stage feeds only the second stage
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule // dpbf_sync

// [design/dpbf_top.sv]
// Function
// - Reset clears pointers and sets flag levels
// - Reset forces the mailbox flag inactive high
// - Input-ready rises two edges after release
// - Reset release captures both offset selects
// - Mode sampled at second edge after release
// - Standard reads every word; fall-through first
// - First four writes load offsets in order
// - Offsets come from low port A bits
// - Port B ready rises after offsets loaded
// - Port A drives only when selected, reading
// - Port A writes FIFO1, reads FIFO2
// - Port B direction polarity inverted, drives reading
// - Port B writes FIFO2, reads FIFO1
// - Fall-through loads output on ready edge
// - Reads ignored when empty, writes when full
// - Flags use one pointer sync stage; fall-through reads use two
// - Output-ready rises on third reading edge
// - Empty and ready rise on second edge
// - Edge coincident with transfer counts next
// - Mailbox select routes transfer to mailbox
// - Non-zero selects load preset 8/16/64
`include "dpbf_params.svh"

module dpbf_top (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Reset, mode and offset pins
   input  wire logic        fifo1_master_reset_n,
   input  wire logic        fifo2_master_reset_n,
   input  wire logic        offset_select_0,
   input  wire logic        offset_select_1,
   input  wire logic        serial_program_select,
   input  wire logic        fallthrough_select,
   // Port A
   input  wire logic        port_a_clock,
   input  wire logic        port_a_select_n,
   input  wire logic        port_a_write_read,
   input  wire logic        port_a_enable,
   input  wire logic        port_a_mail_select,
   input  wire logic [35:0] port_a_data_in,
   output logic      [35:0] port_a_data_out,
   output logic             port_a_data_oe,
   output logic             a_full_or_input_ready,
   output logic             a_empty_or_output_ready,
   output logic             a_almost_empty_n,
   output logic             a_almost_full_n,
   output logic             mail1_full_n,
   // Port B
   input  wire logic        port_b_clock,
   input  wire logic        port_b_select_n,
   input  wire logic        port_b_write_read,
   input  wire logic        port_b_enable,
   input  wire logic        port_b_mail_select,
   input  wire logic [35:0] port_b_data_in,
   output logic      [35:0] port_b_data_out,
   output logic             port_b_data_oe,
   output logic             b_full_or_input_ready,
   output logic             b_empty_or_output_ready,
   output logic             b_almost_empty_n,
   output logic             b_almost_full_n,
   output logic             mail2_full_n
);

   // Binary to Gray before a pointer crosses to the other port
   function automatic logic [10:0] to_gray(input logic [10:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   function automatic logic [10:0] from_gray(input logic [10:0] g);
      logic [10:0] b;
      b[10] = g[10];
      for (int i = 9; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      from_gray = b;
   endfunction

   dpbf_pkg::dpbf_state_t st_q;
   dpbf_pkg::dpbf_state_t st_d;
   logic [35:0]           mem_q [0:1][0:1023];

   // Synchronised pins
   logic        a_clk_s;
   logic        b_clk_s;
   logic [1:0]  mres_n_s;
   logic        fs0_s;
   logic        fs1_s;
   logic        spm_s;
   logic        ft_sel_s;
   logic        a_sel_n_s;
   logic        a_wr_s;
   logic        a_en_s;
   logic        a_mb_s;
   logic [35:0] a_din_s;
   logic        b_sel_n_s;
   logic        b_wr_s;
   logic        b_en_s;
   logic        b_mb_s;
   logic [35:0] b_din_s;

   // Per-direction events: index 0 is FIFO1 (A to B), index 1 is FIFO2
   logic             a_rise;
   logic             b_rise;
   logic             a_go;
   logic             b_go;
   logic [1:0]       wr_rise;
   logic [1:0]       rd_rise;
   logic [1:0]       wr_req;
   logic [1:0]       rd_req;
   logic [1:0]       mwr_req;
   logic [1:0]       mrd_req;
   logic [1:0]       mres_rise;
   logic [1:0][35:0] wdata;
   logic [1:0]       mem_we;
   logic [1:0][9:0]  mem_wa;
   logic             prog_busy;
   logic             apb_wr;

   // Pins cross through two flops
   dpbf_sync #(.W(88)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .d       ({port_a_clock, port_b_clock, fifo2_master_reset_n, fifo1_master_reset_n,
                 offset_select_0, offset_select_1, serial_program_select, fallthrough_select,
                 port_a_select_n, port_a_write_read, port_a_enable, port_a_mail_select, port_a_data_in,
                 port_b_select_n, port_b_write_read, port_b_enable, port_b_mail_select, port_b_data_in}),
      .q       ({a_clk_s, b_clk_s, mres_n_s, fs0_s, fs1_s, spm_s, ft_sel_s,
                 a_sel_n_s, a_wr_s, a_en_s, a_mb_s, a_din_s,
                 b_sel_n_s, b_wr_s, b_en_s, b_mb_s, b_din_s})
   );

   // Port decode; B write/read polarity is the inverse of A
   always_comb begin
      a_rise    = a_clk_s & ~st_q.a_clk_prev;
      b_rise    = b_clk_s & ~st_q.b_clk_prev;
      a_go      = a_rise & ~a_sel_n_s & a_en_s & st_q.ctrl[`DPBF_CTRL_A_BIT];
      b_go      = b_rise & ~b_sel_n_s & b_en_s & st_q.ctrl[`DPBF_CTRL_B_BIT];
      wr_rise   = {b_rise, a_rise};
      rd_rise   = {a_rise, b_rise};
      wr_req    = {b_go & ~b_wr_s & ~b_mb_s, a_go & a_wr_s & ~a_mb_s};
      rd_req    = {a_go & ~a_wr_s & ~a_mb_s, b_go & b_wr_s & ~b_mb_s};
      mwr_req   = {b_go & ~b_wr_s & b_mb_s, a_go & a_wr_s & a_mb_s};
      mrd_req   = {a_go & ~a_wr_s & a_mb_s, b_go & b_wr_s & b_mb_s};
      mres_rise = mres_n_s & ~st_q.mres_prev;
      wdata     = {b_din_s, a_din_s};
      prog_busy = st_q.prog != dpbf_pkg::DPBF_PR_OFF;
      apb_wr    = psel & penable & pwrite;
   end

   // Next state
   always_comb begin
      logic [10:0] wsync;
      logic [10:0] rsync;
      logic [10:0] used;
      logic        ready;
      wsync   = '0;
      rsync   = '0;
      used    = '0;
      ready   = 1'b0;
      st_d    = st_q;
      mem_we  = '0;
      mem_wa  = '0;
      st_d.a_clk_prev = a_clk_s;
      st_d.b_clk_prev = b_clk_s;
      st_d.mres_prev  = mres_n_s;

      for (int f = 0; f < 2; f++) begin
         if (!mres_n_s[f]) begin
            // Held in reset
            st_d.fifo[f].wptr   = '0;
            st_d.fifo[f].rptr   = '0;
            st_d.fifo[f].wg_s1  = '0;
            st_d.fifo[f].wg_s2  = '0;
            st_d.fifo[f].rg_s1  = '0;
            st_d.fifo[f].rg_s2  = '0;
            st_d.fifo[f].ir     = 1'b0;
            st_d.fifo[f].orf    = 1'b0;
            st_d.fifo[f].ae_n   = 1'b0;
            st_d.fifo[f].af_n   = 1'b1;
            st_d.fifo[f].mail_n = 1'b1;
            st_d.fifo[f].wcnt   = '0;
            st_d.fifo[f].dout   = '0;
         end else begin
            // Offset method caught on the release edge
            if (mres_rise[f] && (fs0_s || fs1_s)) begin
               unique case ({fs1_s, fs0_s})
                  2'b11:   st_d.fifo[f].xoff = `DPBF_PRESET_64;
                  2'b10:   st_d.fifo[f].xoff = `DPBF_PRESET_16;
                  default: st_d.fifo[f].xoff = `DPBF_PRESET_8;
               endcase
               st_d.fifo[f].yoff = st_d.fifo[f].xoff;
            end

            // Write side
            if (wr_rise[f]) begin
               st_d.fifo[f].rg_s1 = to_gray(st_q.fifo[f].rptr);
               st_d.fifo[f].rg_s2 = st_q.fifo[f].rg_s1;
               if (st_q.fifo[f].wcnt != `DPBF_READY_EDGES) begin
                  st_d.fifo[f].wcnt = st_q.fifo[f].wcnt + 2'h1;
                  if (st_d.fifo[f].wcnt == `DPBF_READY_EDGES) begin
                     st_d.fifo[f].fall_through_mode = ~ft_sel_s;
                  end
               end
               if (wr_req[f] && st_q.fifo[f].ir) begin
                  if (f == 0 && prog_busy) begin
                     // Loader swallows the word instead of storing it
                     unique case (st_q.prog)
                        dpbf_pkg::DPBF_PR_Y1: st_d.fifo[0].yoff = wdata[0][9:0];
                        dpbf_pkg::DPBF_PR_X1: st_d.fifo[0].xoff = wdata[0][9:0];
                        dpbf_pkg::DPBF_PR_Y2: st_d.fifo[1].yoff = wdata[0][9:0];
                        dpbf_pkg::DPBF_PR_X2: st_d.fifo[1].xoff = wdata[0][9:0];
                        default:              st_d.fifo[0].yoff = st_q.fifo[0].yoff;
                     endcase
                     st_d.prog = (st_q.prog == dpbf_pkg::DPBF_PR_X2) ? dpbf_pkg::DPBF_PR_OFF
                                 : dpbf_pkg::dpbf_prog_t'(st_q.prog + 3'h1);
                  end else begin
                     mem_we[f] = 1'b1;
                     mem_wa[f] = st_q.fifo[f].wptr[9:0];
                     st_d.fifo[f].wptr = st_q.fifo[f].wptr + 11'h001;
                  end
               end
               // Second edge after a read
               rsync = from_gray(st_q.fifo[f].rg_s1);
               used  = st_d.fifo[f].wptr - rsync;
               ready = (st_d.fifo[f].wcnt == `DPBF_READY_EDGES) && !(f == 1 && st_d.prog != dpbf_pkg::DPBF_PR_OFF);
               st_d.fifo[f].ir   = ready && (used != `DPBF_DEPTH);
               st_d.fifo[f].af_n = (`DPBF_DEPTH - used) > {1'b0, st_q.fifo[f].yoff};
            end

            // Read side
            if (rd_rise[f]) begin
               st_d.fifo[f].wg_s1 = to_gray(st_q.fifo[f].wptr);
               st_d.fifo[f].wg_s2 = st_q.fifo[f].wg_s1;
               if (st_q.fifo[f].fall_through_mode) begin
                  // Third edge: stage two counts two
                  wsync = from_gray(st_q.fifo[f].wg_s2);
                  if (!st_q.fifo[f].orf || rd_req[f]) begin
                     if (wsync != st_q.fifo[f].rptr) begin
                        st_d.fifo[f].dout = mem_q[f][st_q.fifo[f].rptr[9:0]];
                        st_d.fifo[f].rptr = st_q.fifo[f].rptr + 11'h001;
                        st_d.fifo[f].orf  = 1'b1;
                     end else begin
                        st_d.fifo[f].orf  = 1'b0;
                     end
                  end
               end else begin
                  wsync = from_gray(st_q.fifo[f].wg_s1);
                  if (rd_req[f] && st_q.fifo[f].orf) begin
                     st_d.fifo[f].dout = mem_q[f][st_q.fifo[f].rptr[9:0]];
                     st_d.fifo[f].rptr = st_q.fifo[f].rptr + 11'h001;
                  end
                  st_d.fifo[f].orf = wsync != st_d.fifo[f].rptr;
               end
               st_d.fifo[f].ae_n = (wsync - st_d.fifo[f].rptr) > {1'b0, st_q.fifo[f].xoff};
            end

            // Mailbox: write to an empty mailbox beats a same-cycle read
            if (mwr_req[f] && st_q.fifo[f].mail_n) begin
               st_d.fifo[f].mail   = wdata[f];
               st_d.fifo[f].mail_n = 1'b0;
            end else if (mrd_req[f]) begin
               st_d.fifo[f].mail_n = 1'b1;
            end
         end
      end

      // Parallel loading needs a joint release
      if (&mres_rise && !fs0_s && !fs1_s && spm_s) begin
         st_d.prog = dpbf_pkg::DPBF_PR_Y1;
      end else if (!mres_n_s[0]) begin
         st_d.prog = dpbf_pkg::DPBF_PR_OFF;
      end

      // Registered bus data
      st_d.a_dout = a_mb_s ? st_q.fifo[1].mail : st_q.fifo[1].dout;
      st_d.b_dout = b_mb_s ? st_q.fifo[0].mail : st_q.fifo[0].dout;

      // APB: read data is prepared in the setup phase
      if (psel && !penable) begin
         st_d.slverr = 1'b0;
         unique case (paddr)
            `DPBF_REG_CTRL:   st_d.prdata = {30'h0, st_q.ctrl};
            `DPBF_REG_STATUS: st_d.prdata = {19'h0, prog_busy, st_q.fifo[1].fall_through_mode, st_q.fifo[0].fall_through_mode,
                                             mail2_full_n, mail1_full_n,
                                             b_almost_full_n, b_almost_empty_n, b_empty_or_output_ready,
                                             b_full_or_input_ready, a_almost_full_n, a_almost_empty_n,
                                             a_empty_or_output_ready, a_full_or_input_ready};
            `DPBF_REG_LEVEL1: st_d.prdata = {21'h0, st_q.fifo[0].wptr - st_q.fifo[0].rptr};
            `DPBF_REG_LEVEL2: st_d.prdata = {21'h0, st_q.fifo[1].wptr - st_q.fifo[1].rptr};
            `DPBF_REG_OFS1:   st_d.prdata = {6'h0, st_q.fifo[0].yoff, 6'h0, st_q.fifo[0].xoff};
            `DPBF_REG_OFS2:   st_d.prdata = {6'h0, st_q.fifo[1].yoff, 6'h0, st_q.fifo[1].xoff};
            default: begin
               st_d.prdata = 32'h0;
               st_d.slverr = 1'b1;
            end
         endcase
      end
      if (apb_wr && paddr == `DPBF_REG_CTRL) begin
         st_d.ctrl = pwdata[1:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q      <= '0;
         st_q.ctrl <= `DPBF_CTRL_RESET;
         for (int f = 0; f < 2; f++) begin
            st_q.fifo[f].af_n   <= 1'b1;
            st_q.fifo[f].mail_n <= 1'b1;
            st_q.fifo[f].fall_through_mode   <= 1'b0;
            st_q.fifo[f].xoff   <= `DPBF_OFS_RESET;
            st_q.fifo[f].yoff   <= `DPBF_OFS_RESET;
         end
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Storage arrays; no reset so they map onto RAM
   always_ff @(posedge clk_sys) begin
      for (int f = 0; f < 2; f++) begin
         if (ce && mem_we[f]) begin
            mem_q[f][mem_wa[f]] <= wdata[f];
         end
      end
   end

   // Pin drive, B with inverted sense
   assign port_a_data_oe          = ~a_sel_n_s & ~a_wr_s;
   assign port_b_data_oe          = ~b_sel_n_s & b_wr_s;
   assign port_a_data_out         = st_q.a_dout;
   assign port_b_data_out         = st_q.b_dout;
   assign a_full_or_input_ready   = st_q.fifo[0].ir;
   assign a_empty_or_output_ready = st_q.fifo[1].orf;
   assign a_almost_empty_n        = st_q.fifo[1].ae_n;
   assign a_almost_full_n         = st_q.fifo[0].af_n;
   assign b_full_or_input_ready   = st_q.fifo[1].ir;
   assign b_empty_or_output_ready = st_q.fifo[0].orf;
   assign b_almost_empty_n        = st_q.fifo[0].ae_n;
   assign b_almost_full_n         = st_q.fifo[1].af_n;
   assign mail1_full_n            = st_q.fifo[0].mail_n;
   assign mail2_full_n            = st_q.fifo[1].mail_n;
   assign prdata                  = st_q.prdata;
   assign pslverr                 = st_q.slverr & psel & penable;
   assign pready                  = psel & penable;
endmodule // dpbf_top

// [testbench/dpbf_top_monitor.sv]
module dpbf_top_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic fifo1_master_reset_n,
   input wire logic fifo2_master_reset_n,
   input wire logic port_a_clock,
   input wire logic port_a_select_n,
   input wire logic port_a_write_read,
   input wire logic port_a_mail_select,
   input wire logic port_a_data_oe,
   input wire logic a_full_or_input_ready,
   input wire logic a_empty_or_output_ready,
   input wire logic a_almost_empty_n,
   input wire logic a_almost_full_n,
   input wire logic mail1_full_n,
   input wire logic mail2_full_n,
   input wire logic port_b_clock,
   input wire logic port_b_select_n,
   input wire logic port_b_write_read,
   input wire logic port_b_data_oe,
   input wire logic b_full_or_input_ready,
   input wire logic b_empty_or_output_ready,
   input wire logic b_almost_empty_n,
   input wire logic b_almost_full_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // Checks pause during system reset
   default clocking mon_cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Five cycles cover sync and flag register
   AST_RST1_FLAGS: assert property (!fifo1_master_reset_n [*5] |->
      !a_full_or_input_ready && !b_empty_or_output_ready && !b_almost_empty_n && a_almost_full_n) else $error("FIFO1 reset flags");
   AST_RST2_FLAGS: assert property (!fifo2_master_reset_n [*5] |->
      !b_full_or_input_ready && !a_empty_or_output_ready && !a_almost_empty_n && b_almost_full_n && mail2_full_n) else $error("FIFO2 reset flags");
   AST_RST1_MAIL: assert property (!fifo1_master_reset_n [*5] |-> mail1_full_n)
      else $error("Mail1 reset flag");
   // No ready before the sync sees release
   AST_READY_WAIT: assert property ($rose(fifo1_master_reset_n) |-> !a_full_or_input_ready [*3])
      else $error("Early input-ready");
   // Bus direction after settling
   AST_OE_A_ON: assert property ((!port_a_select_n && !port_a_write_read) [*3] |-> port_a_data_oe)
      else $error("Port A not driving");
   AST_OE_A_OFF: assert property ((port_a_select_n || port_a_write_read) [*3] |-> !port_a_data_oe)
      else $error("Port A driving idle");
   AST_OE_B_ON: assert property ((!port_b_select_n && port_b_write_read) [*3] |-> port_b_data_oe)
      else $error("Port B not driving");
   // Parked port clock freezes its flags
   AST_A_FLAG_HOLD: assert property ((!port_a_clock && fifo1_master_reset_n) [*6] |=> $stable(a_full_or_input_ready))
      else $error("Port A flag moved");
   AST_B_FLAG_HOLD: assert property ((!port_b_clock && fifo1_master_reset_n) [*6] |=> $stable(b_empty_or_output_ready))
      else $error("Port B flag moved");
   AST_MAIL_SET: assert property ($fell(mail1_full_n) |-> port_a_mail_select)
      else $error("Mail1 set unselected");
   // Main scenarios reached
   cover property ($fell(mail1_full_n));
   cover property ($rose(b_empty_or_output_ready));
   cover property ($rose(port_a_data_oe));
endmodule // dpbf_top_monitor

bind dpbf_top dpbf_top_monitor u_monitor (.*);

// [testbench/dpbf_port_model.sv]
module dpbf_port_model (
   input  wire logic        clk_sys,
   output logic             port_a_clock,
   output logic             port_a_select_n,
   output logic             port_a_write_read,
   output logic             port_a_enable,
   output logic             port_a_mail_select,
   output logic [35:0]      port_a_data_in,
   output logic             port_b_clock,
   output logic             port_b_select_n,
   output logic             port_b_write_read,
   output logic             port_b_enable,
   output logic             port_b_mail_select,
   output logic [35:0]      port_b_data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Start deselected, clocks low
   initial begin
      {port_a_clock, port_a_select_n, port_a_write_read, port_a_enable, port_a_mail_select} = 5'h08;
      {port_b_clock, port_b_select_n, port_b_write_read, port_b_enable, port_b_mail_select} = 5'h08;
      {port_a_data_in, port_b_data_in} = 72'h0;
   end
   // Eight cycles per port clock; controls steady around the rise
   task automatic pulse(input logic [1:0] which);
      repeat (3) @(posedge clk_sys);
      port_a_clock <= which[0];
      port_b_clock <= which[1];
      repeat (3) @(posedge clk_sys);
      port_a_clock <= 1'b0;
      port_b_clock <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   // Released bus shows the inverse of its last value
   task automatic a_op(input logic sn, input logic wr, input logic en, input logic mb, input logic [35:0] d);
      {port_a_select_n, port_a_write_read, port_a_enable, port_a_mail_select} <= {sn, wr, en, mb};
      port_a_data_in <= wr ? d : ~port_a_data_in;
      pulse(2'h1);
   endtask
   // Port B writes with write/read low
   task automatic b_op(input logic sn, input logic wr, input logic en, input logic mb, input logic [35:0] d);
      {port_b_select_n, port_b_write_read, port_b_enable, port_b_mail_select} <= {sn, wr, en, mb};
      port_b_data_in <= wr ? ~port_b_data_in : d;
      pulse(2'h2);
   endtask
   // Both clocks run while neither port is enabled
   task automatic idle(input int n);
      port_a_enable <= 1'b0;
      port_b_enable <= 1'b0;
      repeat (n) pulse(2'h3);
   endtask
endmodule // dpbf_port_model

// [testbench/tb_top.sv]
`include "dpbf_params.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        fifo1_master_reset_n, fifo2_master_reset_n, offset_select_0, offset_select_1;
   logic        serial_program_select, fallthrough_select;
   logic        port_a_clock, port_a_select_n, port_a_write_read, port_a_enable, port_a_mail_select;
   logic        port_b_clock, port_b_select_n, port_b_write_read, port_b_enable, port_b_mail_select;
   logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
   logic        port_a_data_oe, a_full_or_input_ready, a_empty_or_output_ready, a_almost_empty_n;
   logic        a_almost_full_n, mail1_full_n, port_b_data_oe, b_full_or_input_ready;
   logic        b_empty_or_output_ready, b_almost_empty_n, b_almost_full_n, mail2_full_n;
   int          failures, total_checks;
   dpbf_top dut (.*);
   dpbf_port_model pm (.*);
   // 10 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // APB master, bounded wait for pready
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      int n;
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, addr, wdata};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
      if (pready !== 1'b1) begin
         failures++;
         give_verdict;
      end
   endtask
   task automatic rchk(input logic [7:0] addr, input logic [35:0] exp);
      apb(1'b0, addr, 32'h0);
      chk({3'h0, err, rd}, exp);
   endtask
   // Joint master reset; pins {select 1, select 0, program, mode}
   task automatic mreset(input logic [3:0] pins);
      {offset_select_1, offset_select_0, serial_program_select, fallthrough_select} <= pins;
      {fifo1_master_reset_n, fifo2_master_reset_n} <= 2'h0;
      pm.idle(4);
      chk(36'({a_full_or_input_ready, b_empty_or_output_ready, b_almost_empty_n, a_almost_full_n, mail1_full_n}), 36'h3);
      {fifo1_master_reset_n, fifo2_master_reset_n} <= 2'h3;
      repeat (2) @(posedge clk_sys);
      pm.idle(1);
      chk(36'(a_full_or_input_ready), 36'h0);
      pm.idle(1);
      chk(36'(a_full_or_input_ready), 36'h1);
   endtask
   task automatic t_std;
      mreset(4'h5);
      rchk(`DPBF_REG_OFS1, 36'h0008_0008);
      pm.a_op(1'b0, 1'b1, 1'b1, 1'b0, 36'h9_1234_5678);
      pm.b_op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
      chk(36'(b_empty_or_output_ready), 36'h0);
      pm.b_op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
      chk({port_b_data_out[34:0], b_empty_or_output_ready}, 36'h1);
      pm.b_op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
      chk(port_b_data_out, 36'h9_1234_5678);
      chk(36'({port_b_data_oe, b_empty_or_output_ready}), 36'h2);
      pm.b_op(1'b0, 1'b1, 1'b1, 1'b0, 36'h0);
      chk(port_b_data_out, 36'h9_1234_5678);
      pm.b_op(1'b0, 1'b0, 1'b1, 1'b0, 36'h5_0000_00A5);
      chk(36'(port_b_data_oe), 36'h0);
      pm.idle(2);
      pm.a_op(1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
      chk(port_a_data_out, 36'h5_0000_00A5);
      chk(36'(port_a_data_oe), 36'h1);
      $display("Standard mode paths done");
   endtask
   task automatic t_fall_through_mode;
      mreset(4'h4);
      pm.a_op(1'b0, 1'b1, 1'b1, 1'b0, 36'h3_CAFE_0001);
      pm.b_op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
      pm.b_op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
      chk(36'(b_empty_or_output_ready), 36'h0);
      pm.b_op(1'b0, 1'b1, 1'b0, 1'b0, 36'h0);
      chk(port_b_data_out, 36'h3_CAFE_0001);
      chk(36'(b_empty_or_output_ready), 36'h1);
      $display("Fall-through mode done");
   endtask
   task automatic t_prog;
      logic [9:0] ofs [4];
      ofs = '{10'h005, 10'h006, 10'h007, 10'h009};
      mreset(4'h3);
      for (int i = 0; i < 4; i++) begin
         pm.a_op(1'b0, 1'b1, 1'b1, 1'b0, {26'h2AAAAAA, ofs[i]});
         pm.idle(1);
         chk(36'(b_full_or_input_ready), 36'(i == 3));
      end
      rchk(`DPBF_REG_OFS1, 36'h0005_0006);
      rchk(`DPBF_REG_OFS2, 36'h0007_0009);
      rchk(`DPBF_REG_LEVEL1, 36'h0);
      $display("Offset loading done");
   endtask
   task automatic t_mail;
      pm.a_op(1'b0, 1'b1, 1'b1, 1'b1, 36'h7_0000_0C0D);
      chk(36'(mail1_full_n), 36'h0);
      pm.b_op(1'b0, 1'b1, 1'b1, 1'b1, 36'h0);
      chk({port_b_data_out[35:1], mail1_full_n}, 36'h7_0000_0C0D);
      apb(1'b1, `DPBF_REG_CTRL, 32'h2);
      pm.a_op(1'b0, 1'b1, 1'b1, 1'b0, 36'h1);
      rchk(`DPBF_REG_LEVEL1, 36'h0);
      apb(1'b1, `DPBF_REG_CTRL, 32'h3);
      rchk(`DPBF_REG_CTRL, 36'h3);
      rchk(8'h40, 36'h1_0000_0000);
      $display("Mailbox and registers done");
   endtask
   initial begin
      {rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'h3, 43'h0};
      {fifo1_master_reset_n, fifo2_master_reset_n, offset_select_0, offset_select_1} = 4'hC;
      {serial_program_select, fallthrough_select} = 2'h1;
      {failures, total_checks} = {32'h0, 32'h0};
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_std;
      t_fall_through_mode;
      t_prog;
      t_mail;
      give_verdict;
   end
endmodule // tb_top
